// *** host_port_select_mux_tb.sv ***
// Testbench joining host end and device end across the shared pin interface.
module host_port_select_mux_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import hpsm_pkg::*;

  // Clock, reset and the user sides of both ends; every input is given a level at time zero.
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic hold_reset = 1'h1;
  logic want_sdio = 1'h0;
  logic want_awake = 1'h1;
  logic high_speed = 1'h0;
  logic miso_on_rise = 1'h0;
  logic tx_cmd = 1'h0;
  logic tx_cmd_drive_low = 1'h1;
  logic [3:0] tx_dat = 4'h0;
  logic [3:0] tx_dat_drive_low = 4'hF;
  logic core_miso = 1'h0;
  logic core_irq = 1'h0;
  logic core_cmd_out = 1'h0;
  logic core_cmd_drive_low = 1'h1;
  logic [3:0] core_dat_out = 4'h0;
  logic [3:0] core_dat_drive_low = 4'hF;
  logic power_save_en = 1'h1;
  logic wake_gpio_out = 1'h0;
  logic wake_gpio_drive_low = 1'h1;
  logic irq_mirror_en = 1'h0;
  logic aux_gpio_out = 1'h0;
  logic aux_gpio_drive_low = 1'h1;
  logic ready;
  logic rx_valid;
  logic rx_cmd;
  logic [3:0] rx_dat;
  hpsm_mode_type port_mode;
  logic port_live;
  logic spi_mosi;
  logic spi_cs_low;
  logic sdio_cmd;
  logic [3:0] sdio_dat;
  logic wake_request;
  // Interrupt as seen by the host, and the link clock as the device end recovers it.
  logic irq_seen;
  logic dev_link_clk;
  logic link_rise;
  logic link_fall;
  // Random state, expected receptions, and the tallies.
  logic [31:0] seed = 32'h9DD6622A;
  logic [4:0] exp_q[$];
  int fails = 0;
  int checked = 0;

  // Free-running local clock of 20 ns.
  always #10 clock = ~clock;

  hpsm_if i_hpsm_if();

  hpsm_host #(.LINK_HALF(8'h04), .WAKE_WAIT(16'h0002)) i_hpsm_host (.clock(clock), .rst(rst), .pins(i_hpsm_if),
    .hold_reset(hold_reset), .want_sdio(want_sdio), .want_awake(want_awake), .high_speed(high_speed),
    .miso_on_rise(miso_on_rise), .tx_cmd(tx_cmd), .tx_cmd_drive_low(tx_cmd_drive_low), .tx_dat(tx_dat),
    .tx_dat_drive_low(tx_dat_drive_low), .ready(ready), .rx_valid(rx_valid), .rx_cmd(rx_cmd), .rx_dat(rx_dat),
    .irq_seen(irq_seen));

  hpsm_device i_hpsm_device (.clock(clock), .rst(rst), .pins(i_hpsm_if), .core_miso(core_miso),
    .core_irq(core_irq), .core_cmd_out(core_cmd_out), .core_cmd_drive_low(core_cmd_drive_low),
    .core_dat_out(core_dat_out), .core_dat_drive_low(core_dat_drive_low), .high_speed(high_speed),
    .power_save_en(power_save_en), .wake_gpio_out(wake_gpio_out), .wake_gpio_drive_low(wake_gpio_drive_low),
    .irq_mirror_en(irq_mirror_en), .aux_gpio_out(aux_gpio_out), .aux_gpio_drive_low(aux_gpio_drive_low),
    .port_mode(port_mode), .port_live(port_live), .link_clk(dev_link_clk), .link_rise(link_rise),
    .link_fall(link_fall), .spi_mosi(spi_mosi),
    .spi_cs_low(spi_cs_low), .sdio_cmd(sdio_cmd), .sdio_dat(sdio_dat), .wake_request(wake_request));

  hpsm_props #(.LINK_HALF(4)) i_hpsm_props (.clock(clock), .rst(rst),
    .device_reset_low(i_hpsm_if.device_reset_low), .link_clk(i_hpsm_if.link_clk),
    .host_wake_out(i_hpsm_if.host_wake_out), .host_port_select(i_hpsm_if.host_port_select), .dat(i_hpsm_if.dat),
    .dev_cmd_out(i_hpsm_if.dev_cmd_out), .dev_cmd_drive_low(i_hpsm_if.dev_cmd_drive_low),
    .dev_dat_out(i_hpsm_if.dev_dat_out), .dev_dat_drive_low(i_hpsm_if.dev_dat_drive_low));

  // Xorshift step; the seed is fixed so every run is the same.
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Compares one result with its expectation and tallies both.
  task automatic check(input logic [4:0] seen, input logic [4:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Notes one expected reception and waits, bounded, for the monitor to take it.
  task automatic expect_rx(input logic [4:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    while (exp_q.size() > 0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check({4'h0, exp_q.size() == 0}, 5'h01);
    exp_q.delete();
  endtask

  // One bit-level transfer; in SDIO the direction is random, in SPI select and data are random.
  task automatic xfer(input logic sdio);
    logic [31:0] r;
    logic [1:0] ups;
    logic [1:0] downs;
    logic [4:0] highs;
    seed = next_rand(seed);
    r = seed;
    core_cmd_drive_low = !(sdio && r[8]);
    core_dat_drive_low = (sdio && r[8]) ? 4'h0 : 4'hF;
    core_cmd_out = r[0];
    core_dat_out = r[4:1];
    core_miso = r[2];
    core_irq = r[3];
    tx_cmd_drive_low = sdio && r[8];
    tx_dat_drive_low = sdio ? (r[8] ? 4'hF : 4'h0) : 4'h7;
    tx_cmd = r[0];
    tx_dat = sdio ? r[4:1] : {r[1], 3'h0};
    // Three link periods let both synchronisers and both launch edges settle.
    // Any 24 cycles of a running 8-cycle link clock hold three rises, three falls and twelve high cycles.
    ups = 2'h0;
    downs = 2'h0;
    highs = 5'h00;
    for (int c = 0; c < 24; c++) begin
      @(negedge clock);
      if (link_rise === 1'h1) ups++;
      if (link_fall === 1'h1) downs++;
      if (dev_link_clk === 1'h1) highs++;
    end
    check({1'h0, ups, downs}, 5'h0F);
    check(highs, 5'h0C);
    if (sdio && !r[8]) check({sdio_cmd, sdio_dat}, {r[0], r[4:1]});
    if (!sdio) check({spi_mosi, spi_cs_low, 3'h0}, {r[0], r[1], 3'h0});
    expect_rx(sdio ? {r[0], r[4:1]} : {r[0], r[1], 1'h1, r[3], r[1] | r[2]});
  endtask

  // Resets both ends in mid-run, takes the strap, then moves data and drops the wake request.
  task automatic run_config(input logic sdio, input logic hs);
    int n;
    rst = 1'h1;
    hold_reset = 1'h1;
    want_sdio = sdio;
    high_speed = hs;
    miso_on_rise = hs;
    core_dat_drive_low = 4'h0;
    repeat (4) @(negedge clock);
    rst = 1'h0;
    repeat (12) @(negedge clock);
    check({port_live, i_hpsm_if.dev_dat_drive_low}, 5'h0F);
    hold_reset = 1'h0;
    n = 0;
    while (ready !== 1'h1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check({port_live, 3'h0, port_mode}, {4'h8, sdio ? hpsm_mode_sdio : hpsm_mode_spi});
    // One link period lets the first recovered edges through before any window is counted.
    repeat (8) @(negedge clock);
    for (int k = 0; k < 6; k++) xfer(sdio);
    want_awake = 1'h0;
    repeat (20) @(negedge clock);
    check({4'h0, ready}, 5'h00);
    want_awake = 1'h1;
  endtask

  // Monitor: each reception takes the oldest note off the queue.
  always @(negedge clock) begin
    if (rx_valid === 1'h1 && exp_q.size() > 0) begin
      check({rx_cmd, rx_dat}, exp_q.pop_front());
    end
  end

  // Main sequence: every strap and speed combination, then the side pins.
  initial begin
    for (int cfg = 0; cfg < 4; cfg++) begin
      run_config(cfg[1], cfg[0]);
    end
    seed = next_rand(seed);
    irq_mirror_en = 1'h1;
    core_irq = seed[0];
    repeat (4) @(negedge clock);
    check({4'h0, i_hpsm_if.aux_irq_pin}, {4'h0, seed[0]});
    check({4'h0, irq_seen}, {4'h0, seed[0]});
    check({4'h0, wake_request}, 5'h01);
    irq_mirror_en = 1'h0;
    aux_gpio_drive_low = 1'h0;
    aux_gpio_out = ~seed[0];
    power_save_en = 1'h0;
    wake_gpio_drive_low = 1'h0;
    repeat (6) @(negedge clock);
    check({4'h0, i_hpsm_if.aux_irq_pin}, {4'h0, ~seed[0]});
    check({4'h0, irq_seen}, {4'h0, ~seed[0]});
    check({4'h0, wake_request}, 5'h00);
    give_verdict();
  end

  // Watchdog: about twenty times the expected length of the run.
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
endmodule

// *** hpsm_defs.svh ***
// Shared constants of the host port select mux: strap codes, timing and counts.
`ifndef HPSM_DEFS_SVH
`define HPSM_DEFS_SVH

// Rate of the local clock in MHz.
`define HPSM_CLK_MHZ 50
// Strap level that picks each port.
`define HPSM_SEL_SPI 1'h0
`define HPSM_SEL_SDIO 1'h1
// Fastest link clock allowed in default and high speed, in MHz.
`define HPSM_SDIO_DS_MAX_MHZ 26
`define HPSM_SDIO_HS_MAX_MHZ 52
// Shortest serial clock period allowed on the SPI port, in ps.
`define HPSM_SPI_TCLK_MIN_PS 19230
// Least half period of the made link clock, rounded up so that 26 MHz is never passed.
`define HPSM_LINK_HALF_MIN ((`HPSM_CLK_MHZ + 2 * `HPSM_SDIO_DS_MAX_MHZ - 1) / (2 * `HPSM_SDIO_DS_MAX_MHZ))
// Default half period of the made link clock in cycles (160 ns period).
`define HPSM_LINK_HALF_DEF 4
// Strap hold count; the strap stays driven this many cycles plus one after the reset pin rises.
`define HPSM_STRAP_HOLD 16'h0004
// Wait after raising the wake request, in ns, and in cycles rounded up.
`define HPSM_WAKE_WAIT_NS 1000
`define HPSM_WAKE_WAIT_CYC ((`HPSM_WAKE_WAIT_NS * `HPSM_CLK_MHZ + 999) / 1000)
// Pin drive patterns: all released, and only data line 2 driven.
`define HPSM_DRIVE_NONE 4'hF
`define HPSM_DRIVE_LINE2 4'hB

`endif

// *** hpsm_device.sv ***
// Device end: strap latch at reset release and routing of the shared host pins.
// Overview of operation
// - Latch strap at reset rise; high picks SDIO.
// - Host holds strap steady across reset rise.
// - SPI: clock, MOSI, MISO, select, IRQ; strap ignored.
// - SDIO: clock, command, data 0-3; strap becomes data 2.
// - Host keeps SDIO clock within 26/52 MHz.
// - Host keeps SPI clock period at least 19.23 ns.
// - Host wakes device through the wake request.
// - Host holds wake low to permit sleep.
// - Wake pin becomes GPIO without power save.
// - Aux pin mirrors IRQ, otherwise acts as GPIO.
// - Host picks MISO sampling edge itself.
// - SDIO capture: rising in HS, falling in DS.
// - Host waits for wake-up before any transaction.
`include "hpsm_defs.svh"

module hpsm_device
  import hpsm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  hpsm_if.device pins,
  // Port side of the core.
  input wire logic core_miso,
  input wire logic core_irq,
  input wire logic core_cmd_out,
  input wire logic core_cmd_drive_low,
  input wire logic [3:0] core_dat_out,
  input wire logic [3:0] core_dat_drive_low,
  input wire logic high_speed,
  input wire logic power_save_en,
  input wire logic wake_gpio_out,
  input wire logic wake_gpio_drive_low,
  input wire logic irq_mirror_en,
  input wire logic aux_gpio_out,
  input wire logic aux_gpio_drive_low,
  output hpsm_mode_type port_mode,
  output logic port_live,
  output logic link_clk,
  output logic link_rise,
  output logic link_fall,
  output logic spi_mosi,
  output logic spi_cs_low,
  output logic sdio_cmd,
  output logic [3:0] sdio_dat,
  output logic wake_request
);

  // Present and next state.
  hpsm_dev_state_type s;
  hpsm_dev_state_type next_s;
  // Edges of the synchronised link clock.
  logic rise;
  logic fall;
  // Edge on which the device changes its outgoing port data.
  logic launch;

  // Edges are found on the second synchroniser stage only.
  assign rise = s.clk_s2 & ~s.clk_d;
  assign fall = ~s.clk_s2 & s.clk_d;

  // Next state of the whole end.
  always_comb begin
    next_s = s;
    // Every pin passes two flip-flops before any logic looks at it.
    next_s.rel_s1 = pins.device_reset_low;
    next_s.rel_s2 = s.rel_s1;
    next_s.rel_d = s.rel_s2;
    next_s.sel_s1 = pins.host_port_select;
    next_s.sel_s2 = s.sel_s1;
    next_s.clk_s1 = pins.link_clk;
    next_s.clk_s2 = s.clk_s1;
    next_s.clk_d = s.clk_s2;
    next_s.cmd_s1 = pins.cmd;
    next_s.cmd_s2 = s.cmd_s1;
    next_s.dat_s1 = pins.dat;
    next_s.dat_s2 = s.dat_s1;
    next_s.wake_s1 = pins.wake_request_pin;
    next_s.wake_s2 = s.wake_s1;
    // The strap runs through the same two stages as the reset pin, so both are seen in one cycle.
    if (s.rel_s2 && !s.rel_d) begin
      next_s.mode = (s.sel_s2 == `HPSM_SEL_SDIO) ? hpsm_mode_sdio : hpsm_mode_spi;
    end
    // The port is live from the cycle the strap is taken until the reset pin falls again.
    next_s.live = s.rel_s2;
    // HS data changes on the falling edge so the host takes it rising; DS the other way.
    if (s.mode == hpsm_mode_sdio && !high_speed) begin
      launch = rise;
    end else begin
      launch = fall;
    end
    if (!next_s.live) begin
      // While the reset pin is low nothing is driven and no pin reaches the core.
      next_s.cmd_drive_low = 1'h1;
      next_s.dat_drive_low = `HPSM_DRIVE_NONE;
      next_s.wake_drive_low = 1'h1;
      next_s.aux_drive_low = 1'h1;
      next_s.cmd_out = 1'h0;
      next_s.dat_out = 4'h0;
      next_s.wake_out = 1'h0;
      next_s.aux_out = 1'h0;
      next_s.link_clk = 1'h0;
      next_s.link_rise = 1'h0;
      next_s.link_fall = 1'h0;
      next_s.spi_mosi = 1'h0;
      next_s.spi_cs_low = 1'h1;
      next_s.sdio_cmd = 1'h0;
      next_s.sdio_dat = 4'h0;
      next_s.wake_request = 1'h0;
    end else begin
      next_s.link_clk = s.clk_s2;
      next_s.link_rise = rise;
      next_s.link_fall = fall;
      if (next_s.mode == hpsm_mode_spi) begin
        // Command line is MOSI and data line 3 the chip select; line 2 is never read.
        next_s.spi_mosi = s.cmd_s2;
        next_s.spi_cs_low = s.dat_s2[3];
        next_s.sdio_cmd = 1'h0;
        next_s.sdio_dat = 4'h0;
        next_s.cmd_drive_low = 1'h1;
        // MISO is driven only while selected, so several targets may share it.
        // Line 1 carries the interrupt at all times; line 0 follows the synchronised chip select.
        next_s.dat_drive_low = {2'h3, 1'h0, s.dat_s2[3]};
        // The interrupt request follows the core on every cycle.
        next_s.dat_out[1] = core_irq;
        // MISO moves on the falling edge; the host may take it on either edge.
        if (fall) begin
          next_s.dat_out[0] = core_miso;
        end
      end else begin
        // All four data lines and the command line belong to the SDIO core.
        next_s.spi_mosi = 1'h0;
        next_s.spi_cs_low = 1'h1;
        next_s.sdio_cmd = s.cmd_s2;
        next_s.sdio_dat = s.dat_s2;
        if (launch) begin
          next_s.cmd_out = core_cmd_out;
          next_s.cmd_drive_low = core_cmd_drive_low;
          next_s.dat_out = core_dat_out;
          next_s.dat_drive_low = core_dat_drive_low;
        end
      end
      next_s.wake_request = s.wake_s2;
      // Without power save the wake pin is free as a general purpose line.
      if (power_save_en) begin
        next_s.wake_drive_low = 1'h1;
        next_s.wake_out = 1'h0;
      end else begin
        next_s.wake_drive_low = wake_gpio_drive_low;
        next_s.wake_out = wake_gpio_out;
      end
      // The auxiliary pin repeats the port interrupt, or else serves as a general purpose line.
      if (irq_mirror_en) begin
        next_s.aux_drive_low = 1'h0;
        next_s.aux_out = core_irq;
      end else begin
        next_s.aux_drive_low = aux_gpio_drive_low;
        next_s.aux_out = aux_gpio_out;
      end
    end
  end

  // State register; reset leaves every line released and the port in SPI mode.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.cmd_drive_low <= 1'h1;
      s.dat_drive_low <= `HPSM_DRIVE_NONE;
      s.wake_drive_low <= 1'h1;
      s.aux_drive_low <= 1'h1;
      s.spi_cs_low <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  // Pins and core outputs come straight from the state register.
  assign pins.dev_cmd_out = s.cmd_out;
  assign pins.dev_cmd_drive_low = s.cmd_drive_low;
  assign pins.dev_dat_out = s.dat_out;
  assign pins.dev_dat_drive_low = s.dat_drive_low;
  assign pins.dev_wake_out = s.wake_out;
  assign pins.dev_wake_drive_low = s.wake_drive_low;
  assign pins.aux_out = s.aux_out;
  assign pins.aux_drive_low = s.aux_drive_low;
  assign port_mode = s.mode;
  assign port_live = s.live;
  assign link_clk = s.link_clk;
  assign link_rise = s.link_rise;
  assign link_fall = s.link_fall;
  assign spi_mosi = s.spi_mosi;
  assign spi_cs_low = s.spi_cs_low;
  assign sdio_cmd = s.sdio_cmd;
  assign sdio_dat = s.sdio_dat;
  assign wake_request = s.wake_request;

endmodule

// *** hpsm_host.sv ***
// Host end: reset and strap sequence, wake request, link clock and data transfer.
`include "hpsm_defs.svh"

module hpsm_host
  import hpsm_pkg::*;
#(
  parameter logic [7:0] LINK_HALF = 8'(`HPSM_LINK_HALF_DEF),
  parameter logic [15:0] WAKE_WAIT = 16'(`HPSM_WAKE_WAIT_CYC)
)
(
  input wire logic clock,
  input wire logic rst,
  hpsm_if.host pins,
  input wire logic hold_reset,
  input wire logic want_sdio,
  input wire logic want_awake,
  input wire logic high_speed,
  input wire logic miso_on_rise,
  input wire logic tx_cmd,
  input wire logic tx_cmd_drive_low,
  input wire logic [3:0] tx_dat,
  input wire logic [3:0] tx_dat_drive_low,
  output logic ready,
  output logic rx_valid,
  output logic rx_cmd,
  output logic [3:0] rx_dat,
  output logic irq_seen
);

  // Present and next state.
  hpsm_host_state_type s;
  hpsm_host_state_type next_s;
  // True when the far end is sampled after a rising edge.
  logic cap_rise;

  // Next state of the whole end.
  always_comb begin
    next_s = s;
    next_s.cmd_s1 = pins.cmd;
    next_s.cmd_s2 = s.cmd_s1;
    next_s.dat_s1 = pins.dat;
    next_s.dat_s2 = s.dat_s1;
    next_s.aux_s1 = pins.aux_irq_pin;
    next_s.aux_s2 = s.aux_s1;
    next_s.rx_valid = 1'h0;
    next_s.irq_seen = s.ready & s.aux_s2;
    // SDIO edge follows the speed mode; for SPI the user picks.
    cap_rise = s.sdio ? high_speed : miso_on_rise;
    unique case (s.step)
      hpsm_hst_reset: begin
        // Only the strap is driven while the reset pin is held low.
        next_s.sdio = want_sdio;
        next_s.dat_out = {1'h0, want_sdio, 2'h0};
        next_s.dat_drive_low = `HPSM_DRIVE_LINE2;
        next_s.cmd_drive_low = 1'h1;
        if (!hold_reset) begin
          next_s.reset_low_out = 1'h1;
          next_s.cnt = `HPSM_STRAP_HOLD;
          next_s.step = hpsm_hst_strap;
        end
      end
      hpsm_hst_strap: begin
        // The strap stays put until the device has surely taken it.
        if (s.cnt == 16'h0000) begin
          next_s.dat_drive_low = `HPSM_DRIVE_NONE;
          next_s.cnt = WAKE_WAIT;
          next_s.step = hpsm_hst_wake;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      hpsm_hst_wake: begin
        // The port may be asleep, so nothing moves until the wait has run out.
        next_s.wake_out = want_awake;
        if (!want_awake) begin
          next_s.cnt = WAKE_WAIT;
        end else if (s.cnt == 16'h0000) begin
          next_s.ready = 1'h1;
          next_s.step = hpsm_hst_run;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      hpsm_hst_run: begin
        if (!want_awake && !s.link_clk) begin
          // Dropping the wake request lets the device sleep; a high half runs out first so no short pulse leaves.
          next_s.wake_out = 1'h0;
          next_s.ready = 1'h0;
          next_s.link_clk = 1'h0;
          next_s.div = 8'h00;
          next_s.cnt = WAKE_WAIT;
          next_s.step = hpsm_hst_wake;
        end else if (s.div == LINK_HALF - 8'h01) begin
          // The half period is never below the minimum that keeps within the rate limits.
          next_s.div = 8'h00;
          next_s.link_clk = ~s.link_clk;
          // Host data changes on the falling edge.
          if (s.link_clk) begin
            next_s.cmd_out = tx_cmd;
            next_s.cmd_drive_low = tx_cmd_drive_low;
            next_s.dat_out = tx_dat;
            next_s.dat_drive_low = tx_dat_drive_low;
          end
          // Sampling at the end of the half after the capture edge covers both synchronisers.
          if (s.link_clk == cap_rise) begin
            next_s.rx_valid = 1'h1;
            next_s.rx_cmd = s.cmd_s2;
            next_s.rx_dat = s.dat_s2;
          end
        end else begin
          next_s.div = s.div + 8'h01;
        end
      end
    endcase
    // Holding reset aborts any step and goes back to the reset step.
    if (hold_reset && s.step != hpsm_hst_reset) begin
      next_s.step = hpsm_hst_reset;
      next_s.reset_low_out = 1'h0;
      next_s.link_clk = 1'h0;
      next_s.div = 8'h00;
      next_s.wake_out = 1'h0;
      next_s.ready = 1'h0;
      next_s.rx_valid = 1'h0;
      next_s.cmd_drive_low = 1'h1;
      next_s.dat_drive_low = `HPSM_DRIVE_NONE;
    end
  end

  // State register; reset holds the device in reset with all lines released.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.cmd_drive_low <= 1'h1;
      s.dat_drive_low <= `HPSM_DRIVE_NONE;
    end else begin
      s <= next_s;
    end
  end

  // Pins and user outputs come straight from the state register.
  assign pins.device_reset_low = s.reset_low_out;
  assign pins.link_clk = s.link_clk;
  assign pins.host_cmd_out = s.cmd_out;
  assign pins.host_cmd_drive_low = s.cmd_drive_low;
  assign pins.host_dat_out = s.dat_out;
  assign pins.host_dat_drive_low = s.dat_drive_low;
  assign pins.host_wake_out = s.wake_out;
  assign ready = s.ready;
  assign rx_valid = s.rx_valid;
  assign rx_cmd = s.rx_cmd;
  assign rx_dat = s.rx_dat;
  assign irq_seen = s.irq_seen;

endmodule

// *** hpsm_if.sv ***
// Shared pins between the host end and the device end, with wire resolution.
interface hpsm_if;

  // Drives of the host end.
  logic device_reset_low;
  logic link_clk;
  logic host_cmd_out;
  logic host_cmd_drive_low;
  logic [3:0] host_dat_out;
  logic [3:0] host_dat_drive_low;
  logic host_wake_out;
  // Drives of the device end.
  logic dev_cmd_out;
  logic dev_cmd_drive_low;
  logic [3:0] dev_dat_out;
  logic [3:0] dev_dat_drive_low;
  logic dev_wake_out;
  logic dev_wake_drive_low;
  logic aux_out;
  logic aux_drive_low;
  // Resolved levels; undriven command and data lines read high as through a pull-up.
  logic cmd;
  logic [3:0] dat;
  logic host_port_select;
  logic wake_request_pin;
  logic aux_irq_pin;

  // The device wins a contested line so that a misbehaving device shows as a wrong level.
  assign cmd = !dev_cmd_drive_low ? dev_cmd_out : (!host_cmd_drive_low ? host_cmd_out : 1'h1);
  for (genvar i = 0; i < 4; i++) begin : g_dat
    assign dat[i] = !dev_dat_drive_low[i] ? dev_dat_out[i] : (!host_dat_drive_low[i] ? host_dat_out[i] : 1'h1);
  end
  // The strap shares its pin with data line 2.
  assign host_port_select = dat[2];
  assign wake_request_pin = !dev_wake_drive_low ? dev_wake_out : host_wake_out;
  // The auxiliary line reads low when nobody drives it.
  assign aux_irq_pin = !aux_drive_low ? aux_out : 1'h0;

  modport device (
    input device_reset_low, link_clk, cmd, dat, host_port_select, wake_request_pin,
    output dev_cmd_out, dev_cmd_drive_low, dev_dat_out, dev_dat_drive_low,
    output dev_wake_out, dev_wake_drive_low, aux_out, aux_drive_low
  );

  modport host (
    output device_reset_low, link_clk, host_cmd_out, host_cmd_drive_low,
    output host_dat_out, host_dat_drive_low, host_wake_out,
    input cmd, dat, aux_irq_pin
  );

endinterface

// *** hpsm_pkg.sv ***
// Types shared by both ends of the host port select mux.
package hpsm_pkg;

  // Host port chosen by the strap.
  typedef enum logic {
    hpsm_mode_spi,
    hpsm_mode_sdio
  } hpsm_mode_type;

  // Sequence of the host end.
  typedef enum logic [1:0] {
    hpsm_hst_reset,
    hpsm_hst_strap,
    hpsm_hst_wake,
    hpsm_hst_run
  } hpsm_host_step_type;

  // Whole state of the device end.
  typedef struct packed {
    logic rel_s1;
    logic rel_s2;
    logic rel_d;
    logic sel_s1;
    logic sel_s2;
    logic clk_s1;
    logic clk_s2;
    logic clk_d;
    logic cmd_s1;
    logic cmd_s2;
    logic [3:0] dat_s1;
    logic [3:0] dat_s2;
    logic wake_s1;
    logic wake_s2;
    hpsm_mode_type mode;
    logic live;
    logic cmd_out;
    logic cmd_drive_low;
    logic [3:0] dat_out;
    logic [3:0] dat_drive_low;
    logic wake_out;
    logic wake_drive_low;
    logic aux_out;
    logic aux_drive_low;
    logic link_clk;
    logic link_rise;
    logic link_fall;
    logic spi_mosi;
    logic spi_cs_low;
    logic sdio_cmd;
    logic [3:0] sdio_dat;
    logic wake_request;
  } hpsm_dev_state_type;

  // Whole state of the host end.
  typedef struct packed {
    hpsm_host_step_type step;
    logic [15:0] cnt;
    logic [7:0] div;
    logic link_clk;
    logic reset_low_out;
    logic sdio;
    logic cmd_out;
    logic cmd_drive_low;
    logic [3:0] dat_out;
    logic [3:0] dat_drive_low;
    logic wake_out;
    logic cmd_s1;
    logic cmd_s2;
    logic [3:0] dat_s1;
    logic [3:0] dat_s2;
    logic aux_s1;
    logic aux_s2;
    logic ready;
    logic rx_valid;
    logic rx_cmd;
    logic [3:0] rx_dat;
    logic irq_seen;
  } hpsm_host_state_type;

endpackage

// *** hpsm_props.sv ***
// Pin-level checker for the two ends of the host port select mux.
module hpsm_props #(
  parameter int LINK_HALF = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic device_reset_low,
  input wire logic link_clk,
  input wire logic host_wake_out,
  input wire logic host_port_select,
  input wire logic [3:0] dat,
  input wire logic dev_cmd_out,
  input wire logic dev_cmd_drive_low,
  input wire logic [3:0] dev_dat_out,
  input wire logic [3:0] dev_dat_drive_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Strap level taken at the last rise of the reset pin.
  logic exp_sdio;
  // Reset pin and link clock as seen one edge earlier.
  logic pin_q;
  logic link_q;
  // Edges the link clock has kept its level; it saturates so that a stopped clock never wraps.
  logic [7:0] held;

  // Helper state that works out from the pins what the device ought to have chosen.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      exp_sdio <= 1'h0;
      pin_q <= 1'h0;
      link_q <= 1'h0;
      held <= 8'hFF;
    end else begin
      pin_q <= device_reset_low;
      link_q <= link_clk;
      if (device_reset_low && !pin_q) begin
        exp_sdio <= host_port_select;
      end
      if (link_clk != link_q) begin
        held <= 8'h01;
      end else if (held != 8'hFF) begin
        held <= held + 8'h01;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Release of the reset pin, and a release that picks the SPI port.
  sequence s_pin_rise;
    !device_reset_low ##1 device_reset_low;
  endsequence
  sequence s_spi_up;
    s_pin_rise ##1 !exp_sdio;
  endsequence

  AST_STRAP_HOLD: assert property (s_pin_rise |-> $stable(host_port_select) [*4])
    else $error("Strap moved while the device was taking it.");
  AST_RESET_QUIET: assert property ((!device_reset_low) [*5] |-> dev_cmd_drive_low && dev_dat_drive_low == 4'hF)
    else $error("Device drives a line while its reset pin is low.");
  AST_SPI_PINS: assert property (device_reset_low && !exp_sdio |-> dev_cmd_drive_low && dev_dat_drive_low[3:2] == 2'h3)
    else $error("Device drives a line that the SPI port leaves to the host.");
  AST_SPI_IRQ_LINE: assert property (s_spi_up |-> ##5 !dev_dat_drive_low[1])
    else $error("Interrupt line not driven after SPI start.");
  AST_MISO_CS: assert property ((device_reset_low && !exp_sdio && dat[3]) [*5] |-> dev_dat_drive_low[0])
    else $error("Serial data out driven while the port is deselected.");
  AST_SDIO_LAUNCH: assert property (device_reset_low && exp_sdio && ($changed(dev_dat_out) || $changed(dev_cmd_out))
    |-> held inside {[2:5]})
    else $error("SDIO output changed away from a link clock edge.");
  AST_LINK_RATE: assert property (link_clk != link_q |-> held >= LINK_HALF)
    else $error("Link clock half period too short.");
  AST_HOST_ASLEEP: assert property ((!host_wake_out) [*8] |-> $stable(link_clk))
    else $error("Link clock runs while the wake request is low.");
endmodule
